// [logic/fault_capture_pkg.sv]
package fault_capture_pkg;

  // Fault report
  localparam int unsigned REPORT_DEPTH   = 10;
  localparam logic [3:0]  SLOT_LAST      = 4'h9;
  localparam logic [9:0]  REC_NUM_MIN    = 10'h001;
  localparam logic [9:0]  REC_NUM_MAX    = 10'h3E7;

  // Fault kind codes
  typedef enum logic [3:0] {
    KIND_THREE_PHASE  = 4'b0000,
    KIND_AG           = 4'b0001,
    KIND_BG           = 4'b0010,
    KIND_CG           = 4'b0011,
    KIND_AB           = 4'b0100,
    KIND_ABG          = 4'b0101,
    KIND_BC           = 4'b0110,
    KIND_BCG          = 4'b0111,
    KIND_CA           = 4'b1000,
    KIND_CAG          = 4'b1001,
    kind_not_computed = 4'b1010
  } fault_kind_t;

  typedef struct packed {
    logic [47:0] stamp;
    fault_kind_t kind;
    logic [15:0] distance;
    logic [9:0]  number;
  } fault_entry_t;

  // Waveform capture
  localparam logic [20:0] STORE_BYTES    = 21'h10_0000;
  localparam logic [5:0]  SAMPLE_BYTES   = 6'h26;
  localparam int unsigned ANALOG_CH      = 9;
  localparam logic [6:0]  PRE_MIN        = 7'h05;
  localparam logic [6:0]  PRE_MAX        = 7'h5F;
  localparam logic [6:0]  PRE_DEFAULT    = 7'h1E;
  localparam logic [6:0]  PCT_FULL       = 7'h64;
  localparam logic [4:0]  RECS_MIN       = 5'h01;
  localparam logic [4:0]  RECS_MAX       = 5'h14;
  localparam logic [4:0]  RECS_DEFAULT   = 5'h04;
  localparam logic [6:0]  SPC_DEFAULT    = 7'h40;

  typedef struct packed {
    logic [ANALOG_CH-1:0][31:0] analog;
    logic [15:0]                digital;
  } sample_t;

  typedef enum logic [1:0] {
    CAP_IDLE  = 2'b00,
    CAP_PRE   = 2'b01,
    CAP_POST  = 2'b10,
    CAP_FLUSH = 2'b11
  } cap_state_t;

endpackage : fault_capture_pkg

// [logic/fault_record_capture.sv]
`timescale 1ns/100ps
// What this block does
// - Fault report made on trigger only while report permission is enabled
// - Report trigger starts distance calculation, then writes the report
// - Clear input erases all reports and acknowledges all panel warnings
// - Fault kind holds one of ten types or the not-computed code
// - Last fault date, distance and report number shown as status
// - Report numbers run from 001 to 999
// - Only ten newest reports kept; eleventh overwrites the oldest
// - With panel option on, each new report raises a panel warning
// - Warning stays until enter key; each stored fault acknowledged alone
// - Panel warning always shows the most recent fault
// - One megabyte reserved for capture records
// - Record holds all analog channels plus sixteen digital channels
// - Nine analog channels stored in fixed order
// - Channels six to eight follow wye or delta connection
// - Digital channels and trigger come from status or virtual outputs
// - Capture starts only while capture permission enabled; a started capture runs on if disabled; default enabled
// - Pre-trigger share 5 to 95 percent, default 30
// - Samples per cycle 4, 8, 16, 32 or 64, default 64
// - Record count 1 to 20, default 4; capacity is store over count
// - Each sample is 38 bytes: nine four-byte values then two bytes
// - Overwrite chains records to one megabyte, then halts until trigger released
// - Triggered capture idles only when flushed and trigger released; pre-trigger capture idles when disabled
// - Snapshot event setting enables capture events; default enabled
module fault_record_capture (
  // Clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  // Register port
  input  wire logic [3:0]                   reg_addr_i,
  input  wire logic [31:0]                  reg_wdata_i,
  input  wire logic                         reg_wr_i,
  input  wire logic                         reg_rd_i,
  output logic      [31:0]                  reg_rdata_o,
  // Fault report side
  input  wire logic                         report_trigger_i,
  input  wire logic                         clear_reports_i,
  input  wire logic                         panel_enter_key_i,
  input  wire logic [47:0]                  fault_stamp_i,
  input  wire fault_capture_pkg::fault_kind_t fault_kind_i,
  input  wire logic                         distance_done_i,
  input  wire logic [15:0]                  distance_i,
  output logic                              distance_start_o,
  output fault_capture_pkg::fault_entry_t   last_fault_o,
  output logic                              panel_warning_o,
  output fault_capture_pkg::fault_entry_t   panel_fault_o,
  // Capture side
  input  wire logic                         capture_trigger_i,
  input  wire logic                         sample_tick_i,
  input  wire logic                         wye_connection_i,
  input  wire logic [7:0][31:0]             raw_analog_i,
  input  wire logic [15:0]                  digital_ch_i,
  input  wire logic                         flash_done_i,
  output logic                              store_we_o,
  output logic [19:0]                       store_addr_o,
  output fault_capture_pkg::sample_t        store_data_o,
  output logic                              flash_save_o,
  output logic                              capture_event_o,
  output logic                              capture_busy_o
);

  localparam logic [3:0] A_CTRL  = 4'h0;
  localparam logic [3:0] A_CAPT  = 4'h1;
  localparam logic [3:0] A_STAT  = 4'h2;
  localparam logic [3:0] A_SPR   = 4'h3;

  // Settings register
  logic       rep_en_reg, panel_en_reg, cap_en_reg, snap_en_reg, ovw_en_reg;
  logic [6:0] pre_pct_reg;
  logic [6:0] spc_reg;
  logic [4:0] recs_reg;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rep_en_reg   <= 1'b0;
      panel_en_reg <= 1'b0;
      cap_en_reg   <= 1'b1;
      snap_en_reg  <= 1'b1;
      ovw_en_reg   <= 1'b0;
      pre_pct_reg  <= fault_capture_pkg::PRE_DEFAULT;
      spc_reg      <= fault_capture_pkg::SPC_DEFAULT;
      recs_reg     <= fault_capture_pkg::RECS_DEFAULT;
    end else if (reg_wr_i) begin
      if (reg_addr_i == A_CTRL) begin
        rep_en_reg   <= reg_wdata_i[0];
        panel_en_reg <= reg_wdata_i[1];
        cap_en_reg   <= reg_wdata_i[2];
        snap_en_reg  <= reg_wdata_i[3];
        ovw_en_reg   <= reg_wdata_i[4];
      end
      if (reg_addr_i == A_CAPT) begin
        // Out-of-range settings are ignored, the old value stays
        if (reg_wdata_i[6:0] >= fault_capture_pkg::PRE_MIN &&
            reg_wdata_i[6:0] <= fault_capture_pkg::PRE_MAX)
          pre_pct_reg <= reg_wdata_i[6:0];
        if (reg_wdata_i[14:8] inside {7'h04, 7'h08, 7'h10, 7'h20, 7'h40})
          spc_reg <= reg_wdata_i[14:8];
        if (reg_wdata_i[20:16] >= fault_capture_pkg::RECS_MIN &&
            reg_wdata_i[20:16] <= fault_capture_pkg::RECS_MAX)
          recs_reg <= reg_wdata_i[20:16];
      end
    end
  end

  // Fault report ring
  fault_capture_pkg::fault_entry_t ring_reg [fault_capture_pkg::REPORT_DEPTH];
  logic [3:0] wr_slot_reg;
  logic [3:0] count_reg;
  logic [3:0] unack_reg;
  logic [9:0] next_num_reg;
  logic       trig_d_reg;
  logic       calc_reg;
  logic [47:0] stamp_reg;
  fault_capture_pkg::fault_kind_t kind_reg;
  logic       rep_done;
  logic       trig_rise;

  assign trig_rise = report_trigger_i & ~trig_d_reg;
  assign rep_done  = calc_reg & distance_done_i;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      trig_d_reg       <= 1'b0;
      calc_reg         <= 1'b0;
      distance_start_o <= 1'b0;
      stamp_reg        <= '0;
      kind_reg         <= fault_capture_pkg::kind_not_computed;
    end else begin
      trig_d_reg       <= report_trigger_i;
      distance_start_o <= 1'b0;
      if (trig_rise && rep_en_reg && !calc_reg) begin
        calc_reg         <= 1'b1;
        distance_start_o <= 1'b1;
        stamp_reg        <= fault_stamp_i;
        kind_reg         <= fault_kind_i;
      end else if (rep_done) begin
        calc_reg <= 1'b0;
      end
    end
  end

  // New entry written once the distance is ready
  fault_capture_pkg::fault_entry_t new_entry;
  always_comb begin
    new_entry.stamp    = stamp_reg;
    new_entry.kind     = kind_reg;
    new_entry.distance = distance_i;
    new_entry.number   = next_num_reg;
  end

  genvar g;
  generate
    for (g = 0; g < fault_capture_pkg::REPORT_DEPTH; g++) begin : g_ring
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i)
          ring_reg[g] <= '0;
        else if (rep_done && wr_slot_reg == 4'(g))
          ring_reg[g] <= new_entry;
      end
    end
  endgenerate

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_slot_reg  <= '0;
      count_reg    <= '0;
      next_num_reg <= fault_capture_pkg::REC_NUM_MIN;
      last_fault_o <= '0;
    end else if (rep_done) begin
      // A report completing with a clear still leaves that report stored
      wr_slot_reg  <= (wr_slot_reg == fault_capture_pkg::SLOT_LAST) ?
                      4'h0 : wr_slot_reg + 4'h1;
      if (count_reg != 4'(fault_capture_pkg::REPORT_DEPTH))
        count_reg <= clear_reports_i ? 4'h1 : count_reg + 4'h1;
      else if (clear_reports_i)
        count_reg <= 4'h1;
      next_num_reg <= (next_num_reg == fault_capture_pkg::REC_NUM_MAX) ?
                      fault_capture_pkg::REC_NUM_MIN :
                      next_num_reg + 10'h001;
      last_fault_o <= new_entry;
    end else if (clear_reports_i) begin
      count_reg <= '0;
    end
  end

  // Panel warnings: one acknowledge per stored unacknowledged fault
  logic new_warn;
  assign new_warn = rep_done & panel_en_reg;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      unack_reg       <= '0;
      panel_warning_o <= 1'b0;
      panel_fault_o   <= '0;
    end else begin
      if (new_warn) begin
        panel_fault_o <= new_entry;
        if (clear_reports_i)
          unack_reg <= 4'h1;
        else if (unack_reg != 4'(fault_capture_pkg::REPORT_DEPTH))
          unack_reg <= unack_reg + 4'h1;
        panel_warning_o <= 1'b1;
      end else if (clear_reports_i) begin
        unack_reg       <= '0;
        panel_warning_o <= 1'b0;
      end else if (panel_enter_key_i && unack_reg != 4'h0) begin
        unack_reg       <= unack_reg - 4'h1;
        panel_warning_o <= (unack_reg != 4'h1);
      end
    end
  end

  // Capture engine
  fault_capture_pkg::cap_state_t state_reg, state_next;
  logic [20:0] rec_bytes;
  logic [15:0] samp_per_rec;
  logic [15:0] pre_samples;
  logic [15:0] idx_reg;
  logic [15:0] taken_reg;
  logic [15:0] post_reg;
  logic [20:0] chain_reg;
  logic [19:0] base_reg;
  logic [4:0]  rec_slot_reg;
  logic [9:0]  rec_total_reg;
  logic        ovw_run;
  logic        samp_ok;
  logic        flushed_reg;

  // Division kept combinational; settings change rarely
  assign rec_bytes    = 21'(fault_capture_pkg::STORE_BYTES /
                        21'(recs_reg));
  assign samp_per_rec = 16'(rec_bytes /
                        21'(fault_capture_pkg::SAMPLE_BYTES));
  assign pre_samples  = 16'((32'(samp_per_rec) * 32'(pre_pct_reg)) /
                        32'(fault_capture_pkg::PCT_FULL));
  assign samp_ok      = sample_tick_i;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      fault_capture_pkg::CAP_IDLE:
        if (cap_en_reg) state_next = fault_capture_pkg::CAP_PRE;
      fault_capture_pkg::CAP_PRE:
        if (!cap_en_reg) state_next = fault_capture_pkg::CAP_IDLE;
        else if (capture_trigger_i) state_next = fault_capture_pkg::CAP_POST;
      fault_capture_pkg::CAP_POST:
        if (samp_ok && post_reg + 16'h1 + pre_samples >= samp_per_rec)
          state_next = fault_capture_pkg::CAP_FLUSH;
      fault_capture_pkg::CAP_FLUSH:
        if ((flash_done_i || flushed_reg) && !capture_trigger_i)
          state_next = fault_capture_pkg::CAP_IDLE;
        else if (flash_done_i && ovw_run)
          state_next = fault_capture_pkg::CAP_POST;
      default:
        state_next = fault_capture_pkg::CAP_IDLE;
    endcase
  end

  // Chaining continues while trigger holds and under one megabyte
  assign ovw_run = ovw_en_reg && capture_trigger_i &&
                   (22'(chain_reg) + 22'(rec_bytes) <=
                    22'(fault_capture_pkg::STORE_BYTES));

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) state_reg <= fault_capture_pkg::CAP_IDLE;
    else       state_reg <= state_next;
  end

  // Sample assembly in fixed channel order
  fault_capture_pkg::sample_t smp;
  always_comb begin
    smp.analog[0] = raw_analog_i[0];
    smp.analog[1] = raw_analog_i[1];
    smp.analog[2] = raw_analog_i[2];
    smp.analog[3] = raw_analog_i[3];
    smp.analog[4] = raw_analog_i[4];
    // Wye gives phase-neutral, delta gives differences
    smp.analog[5] = wye_connection_i ? raw_analog_i[5] :
                    raw_analog_i[5] - raw_analog_i[6];
    smp.analog[6] = wye_connection_i ? raw_analog_i[6] :
                    raw_analog_i[6] - raw_analog_i[7];
    smp.analog[7] = wye_connection_i ? raw_analog_i[7] :
                    raw_analog_i[7] - raw_analog_i[5];
    smp.analog[8] = raw_analog_i[7] + raw_analog_i[6] + raw_analog_i[5];
    smp.digital   = digital_ch_i;
  end

  logic writing;
  assign writing = samp_ok &&
                   (state_reg == fault_capture_pkg::CAP_PRE ||
                    state_reg == fault_capture_pkg::CAP_POST);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      idx_reg         <= '0;
      taken_reg       <= '0;
      post_reg        <= '0;
      chain_reg       <= '0;
      base_reg        <= '0;
      rec_slot_reg    <= '0;
      rec_total_reg   <= '0;
      store_we_o      <= 1'b0;
      store_addr_o    <= '0;
      store_data_o    <= '0;
      flash_save_o    <= 1'b0;
      capture_event_o <= 1'b0;
      capture_busy_o  <= 1'b0;
      flushed_reg     <= 1'b0;
    end else begin
      store_we_o      <= writing;
      flash_save_o    <= 1'b0;
      capture_event_o <= 1'b0;
      capture_busy_o  <= (state_reg == fault_capture_pkg::CAP_POST) ||
                         (state_reg == fault_capture_pkg::CAP_FLUSH);
      flushed_reg     <= (state_reg == fault_capture_pkg::CAP_FLUSH) &&
                         (flash_done_i || flushed_reg);
      if (writing) begin
        store_data_o <= smp;
        store_addr_o <= base_reg + 20'(32'(idx_reg) *
                        32'(fault_capture_pkg::SAMPLE_BYTES));
        idx_reg <= (idx_reg + 16'h1 >= samp_per_rec) ? 16'h0 :
                   idx_reg + 16'h1;
        if (state_reg == fault_capture_pkg::CAP_PRE &&
            taken_reg < pre_samples)
          taken_reg <= taken_reg + 16'h1;
        if (state_reg == fault_capture_pkg::CAP_POST)
          post_reg <= post_reg + 16'h1;
      end
      if (state_reg == fault_capture_pkg::CAP_PRE && state_next ==
          fault_capture_pkg::CAP_POST) begin
        post_reg        <= '0;
        capture_event_o <= snap_en_reg;
        chain_reg       <= 21'(rec_bytes);
      end
      if (state_reg == fault_capture_pkg::CAP_POST && state_next ==
          fault_capture_pkg::CAP_FLUSH) begin
        flash_save_o  <= 1'b1;
        rec_total_reg <= (rec_total_reg == fault_capture_pkg::REC_NUM_MAX)
                         ? 10'h001 : rec_total_reg + 10'h001;
        rec_slot_reg  <= (rec_slot_reg + 5'h1 >= recs_reg) ? 5'h0 :
                         rec_slot_reg + 5'h1;
      end
      if (state_reg == fault_capture_pkg::CAP_FLUSH && state_next ==
          fault_capture_pkg::CAP_POST) begin
        // Chained record: next slot, all post samples
        post_reg  <= 16'(0) - pre_samples;
        chain_reg <= chain_reg + 21'(rec_bytes);
        base_reg  <= 20'(32'(rec_slot_reg) * 32'(rec_bytes));
        idx_reg   <= '0;
        capture_event_o <= snap_en_reg;
      end
      if (state_next == fault_capture_pkg::CAP_IDLE) begin
        idx_reg   <= '0;
        taken_reg <= '0;
        base_reg  <= 20'(32'(rec_slot_reg) * 32'(rec_bytes));
      end
    end
  end

  // Register reads, one cycle later
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i)
      reg_rdata_o <= '0;
    else if (reg_rd_i) begin
      case (reg_addr_i)
        A_CTRL: reg_rdata_o <= {27'h0, ovw_en_reg, snap_en_reg, cap_en_reg,
                                panel_en_reg, rep_en_reg};
        A_CAPT: reg_rdata_o <= {11'h0, recs_reg, 1'b0, spc_reg, 1'b0,
                                pre_pct_reg};
        A_STAT: reg_rdata_o <= {6'h0, rec_total_reg, 2'h0, state_reg,
                                unack_reg, count_reg, 4'(kind_reg)};
        A_SPR:  reg_rdata_o <= {16'h0, samp_per_rec};
        default: reg_rdata_o <= '0;
      endcase
    end else
      reg_rdata_o <= '0;
  end

endmodule : fault_record_capture

// [sim/fault_capture_monitor.sv]
`timescale 1ns/100ps
module fault_capture_monitor (
  // Clock and reset
  input wire logic                            clk_i,
  input wire logic                            rst_i,
  // Register port
  input wire logic                            reg_rd_i,
  input wire logic [31:0]                     reg_rdata_o,
  // Fault report side
  input wire logic                            report_trigger_i,
  input wire logic                            clear_reports_i,
  input wire logic                            panel_enter_key_i,
  input wire logic                            distance_done_i,
  input wire logic                            distance_start_o,
  input wire fault_capture_pkg::fault_entry_t last_fault_o,
  input wire logic                            panel_warning_o,
  // Capture side
  input wire logic                            capture_trigger_i,
  input wire logic                            sample_tick_i,
  input wire logic                            flash_done_i,
  input wire logic                            store_we_o,
  input wire logic                            flash_save_o,
  input wire logic                            capture_event_o,
  input wire logic                            capture_busy_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic saved_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i || flash_save_o) saved_reg <= 1'b0;
    else if (flash_done_i) saved_reg <= 1'b1;
  end

  start_cause_a: assert property (
    distance_start_o |-> $past(report_trigger_i) ##1 !distance_start_o)
    else $error("distance start without trigger or too long");
  read_idle_a: assert property (
    !$past(reg_rd_i) |-> reg_rdata_o == 32'h0000_0000)
    else $error("read data outside read answer cycle");
  store_tick_a: assert property (
    store_we_o |-> $past(sample_tick_i))
    else $error("store write not caused by sample tick");
  save_pulse_a: assert property (
    flash_save_o |=> !flash_save_o)
    else $error("flash save longer than one cycle");
  clear_drop_a: assert property (
    clear_reports_i && !distance_done_i |=> !panel_warning_o)
    else $error("warning survived clear");
  number_range_a: assert property (
    $changed(last_fault_o) |-> $past(distance_done_i) &&
      last_fault_o.number >= fault_capture_pkg::REC_NUM_MIN &&
      last_fault_o.number <= fault_capture_pkg::REC_NUM_MAX)
    else $error("last fault changed badly");
  idle_release_a: assert property (
    $fell(capture_busy_o) |-> $past(saved_reg) && !$past(capture_trigger_i, 2))
    else $error("capture left busy too early");
  event_trig_a: assert property (
    capture_event_o |-> (capture_trigger_i || $past(capture_trigger_i))
      ##1 !capture_event_o)
    else $error("capture event without trigger");
  warn_hold_a: assert property (
    panel_warning_o && !panel_enter_key_i && !clear_reports_i
      |=> panel_warning_o)
    else $error("warning dropped without key");
endmodule : fault_capture_monitor

bind fault_record_capture fault_capture_monitor mon (
  .clk_i(clk_i), .rst_i(rst_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .report_trigger_i(report_trigger_i),
  .clear_reports_i(clear_reports_i), .panel_enter_key_i(panel_enter_key_i),
  .distance_done_i(distance_done_i), .distance_start_o(distance_start_o),
  .last_fault_o(last_fault_o), .panel_warning_o(panel_warning_o),
  .capture_trigger_i(capture_trigger_i), .sample_tick_i(sample_tick_i),
  .flash_done_i(flash_done_i), .store_we_o(store_we_o),
  .flash_save_o(flash_save_o), .capture_event_o(capture_event_o),
  .capture_busy_o(capture_busy_o));

// [sim/relay_side_model.sv]
`timescale 1ns/100ps
module relay_side_model #(
  parameter int DIST_LAT  = 3,
  parameter int FLASH_LAT = 20
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Requests from the block
  input  wire logic        distance_start_i,
  input  wire logic        flash_save_i,
  // Answers
  output logic             distance_done_o,
  output logic [15:0]      distance_o,
  output logic             flash_done_o
);
  int          dcnt;
  int          fcnt;
  logic [15:0] served;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dcnt            <= 0;
      fcnt            <= 0;
      served          <= 16'h0000;
      distance_done_o <= 1'b0;
      distance_o      <= 16'hFFFF;
      flash_done_o    <= 1'b0;
    end else begin
      distance_done_o <= (dcnt == 1);
      flash_done_o    <= (fcnt == 1);
      dcnt <= distance_start_i ? DIST_LAT : (dcnt > 0 ? dcnt - 1 : 0);
      fcnt <= flash_save_i ? FLASH_LAT : (fcnt > 0 ? fcnt - 1 : 0);
      // Distance is only valid with done; scrambled otherwise
      if (dcnt == 1) begin
        distance_o <= 16'h1001 + served;
        served     <= served + 16'h0001;
      end else begin
        distance_o <= ~distance_o;
      end
    end
  end
endmodule : relay_side_model

// [sim/fault_record_capture_tb.sv]
`timescale 1ns/100ps
module fault_record_capture_tb;
  logic        clk_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [3:0]  reg_addr_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0000_0000, reg_rdata_o, v;
  logic        report_trigger_i = 1'b0, clear_reports_i = 1'b0;
  logic        panel_enter_key_i = 1'b0, capture_trigger_i = 1'b0;
  logic        sample_tick_i = 1'b0, wye_connection_i = 1'b1, tick_en = 1'b0;
  logic [47:0] fault_stamp_i = 48'h0000_0000_0000;
  fault_capture_pkg::fault_kind_t  fault_kind_i = fault_capture_pkg::KIND_AG;
  fault_capture_pkg::fault_entry_t last_fault_o, panel_fault_o, exp_e;
  fault_capture_pkg::sample_t      store_data_o, last_s;
  logic        distance_done_i, distance_start_o, panel_warning_o;
  logic        flash_done_i, store_we_o, flash_save_o;
  logic        capture_event_o, capture_busy_o;
  logic [15:0] distance_i, digital_ch_i = 16'hA5C3;
  logic [7:0][31:0] raw_analog_i;
  logic [19:0] store_addr_o, last_addr, prev_addr;
  logic [1:0]  tcnt = 2'h0;
  int          fails = 0, num_checks = 0, n_start = 0, n_event = 0;
  int          n_we = 0, k;

  always #2 clk_i = ~clk_i;

  fault_record_capture uut (
    .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .report_trigger_i(report_trigger_i),
    .clear_reports_i(clear_reports_i), .panel_enter_key_i(panel_enter_key_i),
    .fault_stamp_i(fault_stamp_i), .fault_kind_i(fault_kind_i),
    .distance_done_i(distance_done_i), .distance_i(distance_i),
    .distance_start_o(distance_start_o), .last_fault_o(last_fault_o),
    .panel_warning_o(panel_warning_o), .panel_fault_o(panel_fault_o),
    .capture_trigger_i(capture_trigger_i), .sample_tick_i(sample_tick_i),
    .wye_connection_i(wye_connection_i), .raw_analog_i(raw_analog_i),
    .digital_ch_i(digital_ch_i), .flash_done_i(flash_done_i),
    .store_we_o(store_we_o), .store_addr_o(store_addr_o),
    .store_data_o(store_data_o), .flash_save_o(flash_save_o),
    .capture_event_o(capture_event_o), .capture_busy_o(capture_busy_o));

  relay_side_model model (
    .clk_i(clk_i), .rst_i(rst_i), .distance_start_i(distance_start_o),
    .flash_save_i(flash_save_o), .distance_done_o(distance_done_i),
    .distance_o(distance_i), .flash_done_o(flash_done_i));

  // Sample ticks every fourth cycle, as the protection logic would
  always @(posedge clk_i) begin
    tcnt          <= tcnt + 2'h1;
    sample_tick_i <= tick_en && (tcnt == 2'h0);
    n_start       <= n_start + int'(distance_start_o);
    n_event       <= n_event + int'(capture_event_o);
    if (store_we_o) begin
      n_we      <= n_we + 1;
      last_s    <= store_data_o;
      last_addr <= store_addr_o;
      prev_addr <= last_addr;
    end
  end

  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out;
    if (fails == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    @(negedge clk_i);
    d = reg_rdata_o;
  endtask : rd

  task automatic fire(input int n);
    @(posedge clk_i);
    fault_kind_i     <= fault_capture_pkg::fault_kind_t'(n);
    fault_stamp_i    <= 48'h0000_0000_0100 + 48'(n);
    report_trigger_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    report_trigger_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
  endtask : fire

  // Holds the trigger until the record is handed to flash
  task automatic cap;
    @(posedge clk_i);
    capture_trigger_i <= 1'b1;
    for (k = 0; k < 9000 && flash_save_o !== 1'b1; k++) @(negedge clk_i);
    chk(k < 9000, 1'b1);
    @(posedge clk_i);
    capture_trigger_i <= 1'b0;
    @(negedge clk_i);
  endtask : cap

  initial begin
    repeat (60000) @(posedge clk_i);
    fails++;
    close_out();
  end

  initial begin
    for (k = 0; k < 8; k++) raw_analog_i[k] = 32'h0001_0000 + 32'(k);
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(4'h0, v); chk(v, 32'h0000_000C);
    rd(4'h1, v); chk(v, 32'h0004_401E);
    rd(4'h3, v); chk(v, 32'h0000_1AF2);
    rd(4'hF, v); chk(v, 32'h0000_0000);
    fire(1); chk(n_start, 0);
    wr(4'h0, 32'h0000_000F);
    for (int n = 0; n < 11; n++) begin
      fire(n);
      exp_e = {48'h0000_0000_0100 + 48'(n), 4'(n), 16'h1001 + 16'(n),
               10'(n + 1)};
      chk(last_fault_o, exp_e);
      chk(panel_fault_o, exp_e);
      chk(panel_warning_o, 1'b1);
    end
    chk(n_start, 11);
    rd(4'h2, v); chk(v[7:0], 8'hAA);
    chk(v[25:8], 18'h0_001A);
    @(posedge clk_i) panel_enter_key_i <= 1'b1;
    @(posedge clk_i) panel_enter_key_i <= 1'b0;
    rd(4'h2, v); chk(v[11:8], 4'h9);
    chk(panel_warning_o, 1'b1);
    @(posedge clk_i) clear_reports_i <= 1'b1;
    @(posedge clk_i) clear_reports_i <= 1'b0;
    rd(4'h2, v); chk(v[11:4], 8'h00);
    chk(panel_warning_o, 1'b0);
    for (k = 2; k < 7; k++) begin
      wr(4'h1, 32'h0004_001E | (32'h0000_0001 << (k + 8)));
      rd(4'h1, v); chk(v[14:8], 7'h01 << k);
    end
    // Pre 96, 48 samples per cycle and 21 records are all out of range
    wr(4'h1, 32'h0015_3060); rd(4'h1, v); chk(v, 32'h0004_401E);
    wr(4'h1, 32'h0001_405F); rd(4'h3, v); chk(v, 32'h0000_6BCA);
    wr(4'h1, 32'h0014_405F); rd(4'h3, v); chk(v, 32'h0000_0563);
    wr(4'h0, 32'h0000_000B);
    @(posedge clk_i) tick_en <= 1'b1;
    @(posedge clk_i) capture_trigger_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    capture_trigger_i <= 1'b0;
    @(negedge clk_i) chk({capture_busy_o, n_we, n_event}, 0);
    wr(4'h0, 32'h0000_000F);
    repeat (40) @(posedge clk_i);
    @(negedge clk_i);
    for (k = 0; k < 8; k++) chk(last_s.analog[k], raw_analog_i[k]);
    chk(last_s.analog[8], raw_analog_i[5] + raw_analog_i[6] +
        raw_analog_i[7]);
    chk(last_s.digital, digital_ch_i);
    chk(last_addr - prev_addr, 20'h0_0026);
    cap(); chk(n_event, 1);
    chk(capture_busy_o, 1'b1);
    repeat (30) @(negedge clk_i);
    chk(capture_busy_o, 1'b0);
    @(posedge clk_i) wye_connection_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    @(negedge clk_i);
    for (k = 5; k < 8; k++)
      chk(last_s.analog[k],
          32'(raw_analog_i[k] - raw_analog_i[k == 7 ? 5 : k + 1]));
    wr(4'h0, 32'h0000_0007);
    cap(); chk(n_event, 1);
    repeat (30) @(negedge clk_i);
    wr(4'h0, 32'h0000_001F);
    @(posedge clk_i) capture_trigger_i <= 1'b1;
    repeat (400) @(negedge clk_i);
    chk(n_event, 3);
    close_out();
  end
endmodule : fault_record_capture_tb
